// *** rtl/eeprom_params.svh ***
// constants for the two-wire eeprom slave
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
`define MEM_DEPTH 256
`define PAGE_BYTES 8
`define BYTE_BITS 4'h8
`define ACK_SLOT 4'h9
`define SPAN_FULL 2'h0
`define SPAN_FOUR 2'h1
`define SPAN_EIGHT 2'h2
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define CTRL_RESET 1'h0
`define CTRL_VARIANT_BIT 0
`define STAT_PROG_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_PROT_BIT 2
`define STAT_ADDR_LSB 8
`define TYPE_CODE 4'h6
`define CLK_PERIOD_NS 4
`define PROG_TIME_NS 400
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** rtl/eeprom_pkg.sv ***
// types for the two-wire eeprom slave
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVSEL, ST_ADDR, ST_WDATA, ST_RDATA, ST_RACK, ST_PROG
  } state_type;
  typedef logic [7:0] byte_type;
endpackage

// *** rtl/line_sense.sv ***
// synchroniser and edge/condition finder for the two bus lines
`timescale 1ns/1ps
module line_sense (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw lines
  input wire logic sclPin,
  input wire logic sdaPin,
  // decoded events
  output logic sclRise,
  output logic sclFall,
  output logic sdaLvl,
  output logic startSeen,
  output logic stopSeen
);
  logic [2:0] sclQ, sclD, sdaQ, sdaD;

  always_comb begin
    sclD = {sclQ[1:0], sclPin};
    sdaD = {sdaQ[1:0], sdaPin};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclQ <= 3'h7;
      sdaQ <= 3'h7;
    end else begin
      sclQ <= sclD;
      sdaQ <= sdaD;
    end
  end

  // stage 0 only feeds stage 1
  assign sclRise = sclQ[1] & ~sclQ[2];
  assign sclFall = ~sclQ[1] & sclQ[2];
  assign sdaLvl = sdaQ[1];
  assign startSeen = sclQ[1] & sclQ[2] & ~sdaQ[1] & sdaQ[2];
  assign stopSeen = sclQ[1] & sclQ[2] & sdaQ[1] & ~sdaQ[2];
endmodule

// *** rtl/eeprom_i2c_slave.sv ***
// two-wire serial eeprom slave, 256 x 8, with ahb-lite status port
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_i2c_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // two-wire bus
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // straps and control pins
  input wire logic [2:0] selectStrapInputs,
  input wire logic modePin,
  input wire logic writeProtectInput,
  input wire logic supplyOk,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import eeprom_pkg::*;

  function automatic byte_type incAddr(input byte_type a, input logic [1:0] span);
    byte_type n;
    n = a + 8'h01;
    unique case (span)
      `SPAN_FOUR: incAddr = {a[7:2], n[1:0]};
      `SPAN_EIGHT: incAddr = {a[7:3], n[2:0]};
      default: incAddr = n;
    endcase
  endfunction

  logic sclRise, sclFall, sdaLvl, startSeen, stopSeen;
  line_sense u_sense (
    .clk(clk),
    .rst_n(rst_n),
    .sclPin(sclPin),
    .sdaPin(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .sdaLvl(sdaLvl),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // pin synchronisers
  logic [5:0] pinS1Q, pinS2Q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinS1Q <= 6'h00;
      pinS2Q <= 6'h00;
    end else begin
      pinS1Q <= {supplyOk, writeProtectInput, modePin, selectStrapInputs};
      pinS2Q <= pinS1Q;
    end
  end
  logic [2:0] strapS;
  logic modeS, wpS, porOk;
  assign strapS = pinS2Q[2:0];
  assign modeS = pinS2Q[3];
  assign wpS = pinS2Q[4];
  assign porOk = pinS2Q[5];

  // protocol state
  state_type stQ, stD;
  logic [3:0] cntQ, cntD;
  byte_type shQ, shD, addrQ, addrD, baseQ, baseD;
  byte_type bufQ [`PAGE_BYTES];
  byte_type bufD [`PAGE_BYTES];
  logic [7:0] validQ, validD;
  logic sz4Q, sz4D, drvQ, drvD;
  logic [15:0] progCntQ, progCntD;
  byte_type memQ [`MEM_DEPTH];
  byte_type memD [`MEM_DEPTH];
  logic ctrlVariantQ, ctrlVariantD;
  logic protect, match;
  logic [1:0] wspan;

  assign protect = ctrlVariantQ & wpS;
  assign match = (shQ[7:4] == `TYPE_CODE) && (shQ[3:1] == strapS);
  assign wspan = sz4Q ? `SPAN_FOUR : `SPAN_EIGHT;

  always_comb begin
    stD = stQ;
    cntD = cntQ;
    shD = shQ;
    addrD = addrQ;
    baseD = baseQ;
    bufD = bufQ;
    validD = validQ;
    sz4D = sz4Q;
    drvD = drvQ;
    progCntD = progCntQ;
    memD = memQ;
    if (!porOk) begin
      stD = ST_IDLE;
      drvD = 1'b0;
      validD = 8'h00;
    end else if (stQ == ST_PROG) begin
      // starts are ignored while programming
      if (progCntQ == 16'h0000) begin
        for (int i = 0; i < `PAGE_BYTES; i++) begin
          if (validQ[i]) begin
            memD[{baseQ[7:3], 3'(i)}] = bufQ[i];
          end
        end
        validD = 8'h00;
        stD = ST_IDLE;
      end else begin
        progCntD = progCntQ - 16'h0001;
      end
    end else if (startSeen) begin
      stD = ST_DEVSEL;
      cntD = 4'h0;
      drvD = 1'b0;
      validD = 8'h00;
    end else if (stopSeen && stQ != ST_RDATA && stQ != ST_RACK) begin
      drvD = 1'b0;
      stD = ST_IDLE;
      if (stQ == ST_WDATA && (|validQ) && !protect) begin
        stD = ST_PROG;
        progCntD = 16'(`PROG_CYCLES);
      end
    end else begin
      unique case (stQ)
        ST_DEVSEL, ST_ADDR, ST_WDATA: begin
          if (sclRise && cntQ < `BYTE_BITS) begin
            shD = {shQ[6:0], sdaLvl};
            cntD = cntQ + 4'h1;
          end else if (sclFall && cntQ == `BYTE_BITS) begin
            drvD = 1'b1;
            cntD = `ACK_SLOT;
            if (stQ == ST_DEVSEL && !match) begin
              drvD = 1'b0;
              stD = ST_IDLE;
            end else if (stQ == ST_ADDR) begin
              addrD = shQ;
              baseD = shQ;
            end else if (stQ == ST_WDATA) begin
              bufD[addrQ[2:0]] = shQ;
              validD[addrQ[2:0]] = 1'b1;
              addrD = incAddr(addrQ, wspan);
            end
          end else if (sclFall && cntQ == `ACK_SLOT) begin
            drvD = 1'b0;
            cntD = 4'h0;
            if (stQ == ST_DEVSEL && shQ[0]) begin
              stD = ST_RDATA;
              shD = memQ[addrQ];
              drvD = ~memQ[addrQ][7];
            end else if (stQ == ST_DEVSEL) begin
              stD = ST_ADDR;
              sz4D = ~ctrlVariantQ & modeS;
            end else if (stQ == ST_ADDR) begin
              stD = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (sclRise && cntQ < `BYTE_BITS) begin
            shD = {shQ[6:0], 1'b1};
            cntD = cntQ + 4'h1;
          end else if (sclFall && cntQ == `BYTE_BITS) begin
            drvD = 1'b0;
            cntD = 4'h0;
            stD = ST_RACK;
          end else if (sclFall) begin
            drvD = ~shQ[7];
          end
        end
        ST_RACK: begin
          if (sclRise && cntQ == 4'h0) begin
            addrD = incAddr(addrQ, `SPAN_FULL);
            if (sdaLvl) begin
              stD = ST_IDLE;
            end else begin
              cntD = 4'h1;
            end
          end else if (sclFall && cntQ == 4'h1) begin
            stD = ST_RDATA;
            cntD = 4'h0;
            shD = memQ[addrQ];
            drvD = ~memQ[addrQ][7];
          end
        end
        ST_IDLE, ST_PROG: begin
        end
      endcase
    end
  end

  // bus slave
  logic phQ, phD, phWrQ, phWrD;
  logic [31:0] phAdrQ, phAdrD, hrdataD;
  always_comb begin
    phD = hsel && htrans[1] && hready;
    phWrD = hwrite;
    phAdrD = haddr;
    ctrlVariantD = ctrlVariantQ;
    if (phQ && phWrQ && phAdrQ == `REG_CTRL) begin
      ctrlVariantD = hwdata[`CTRL_VARIANT_BIT];
    end
    hrdataD = 32'h0000_0000;
    if (phD && !hwrite) begin
      if (haddr == `REG_CTRL) begin
        hrdataD[`CTRL_VARIANT_BIT] = ctrlVariantQ;
      end else if (haddr == `REG_STATUS) begin
        hrdataD[`STAT_PROG_BIT] = (stQ == ST_PROG);
        hrdataD[`STAT_BUSY_BIT] = (stQ != ST_IDLE);
        hrdataD[`STAT_PROT_BIT] = protect;
        hrdataD[`STAT_ADDR_LSB +: 8] = addrQ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stQ <= ST_IDLE;
      cntQ <= 4'h0;
      shQ <= 8'h00;
      addrQ <= 8'h00;
      baseQ <= 8'h00;
      validQ <= 8'h00;
      sz4Q <= 1'b0;
      drvQ <= 1'b0;
      progCntQ <= 16'h0000;
      ctrlVariantQ <= `CTRL_RESET;
      phQ <= 1'b0;
      phWrQ <= 1'b0;
      phAdrQ <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe_n <= 1'b1;
    end else begin
      stQ <= stD;
      cntQ <= cntD;
      shQ <= shD;
      addrQ <= addrD;
      baseQ <= baseD;
      validQ <= validD;
      sz4Q <= sz4D;
      drvQ <= drvD;
      progCntQ <= progCntD;
      ctrlVariantQ <= ctrlVariantD;
      phQ <= phD;
      phWrQ <= phWrD;
      phAdrQ <= phAdrD;
      hrdata <= hrdataD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe_n <= ~drvD;
    end
  end

  // array and page buffer, no reset
  always_ff @(posedge clk) begin
    memQ <= memD;
    bufQ <= bufD;
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_byteEnd;
    sclFall && cntQ == `BYTE_BITS;
  endsequence

  property p_typeMismatch;
    ((stQ == ST_DEVSEL) && porOk && !startSeen && !stopSeen && shQ[7:4] != `TYPE_CODE)
      and s_byteEnd |=> stQ == ST_IDLE ##1 sdaOe_n;
  endproperty
  a_typeMismatch: assert property (p_typeMismatch) else $error("bad type code acked");

  property p_strapMismatch;
    ((stQ == ST_DEVSEL) && shQ[3:1] != strapS) and s_byteEnd |=> !drvQ;
  endproperty
  a_strapMismatch: assert property (p_strapMismatch) else $error("strap mismatch acked");

  property p_ackSlot;
    ((stQ == ST_ADDR || stQ == ST_WDATA) && porOk && !startSeen && !stopSeen) and s_byteEnd
      |=> ##1 !sdaOe_n;
  endproperty
  a_ackSlot: assert property (p_ackSlot) else $error("no ack after byte");

  property p_protectInhibit;
    stopSeen && protect && stQ == ST_WDATA |=> stQ != ST_PROG;
  endproperty
  a_protectInhibit: assert property (p_protectInhibit) else $error("write while protected");

  property p_stopLaunch;
    stopSeen && porOk && stQ == ST_WDATA && (|validQ) && !protect
      |=> stQ == ST_PROG [*8];
  endproperty
  a_stopLaunch: assert property (p_stopLaunch) else $error("stop did not program");

  property p_supplyLoss;
    !porOk |=> stQ == ST_IDLE ##1 sdaOe_n;
  endproperty
  a_supplyLoss: assert property (p_supplyLoss) else $error("active without supply");

  property p_pageWrap;
    ((stQ == ST_WDATA) && porOk && !startSeen && !stopSeen) and s_byteEnd
      |=> addrQ[7:3] == $past(addrQ[7:3]) && (!sz4Q || addrQ[2] == $past(addrQ[2]))
      && addrQ[1:0] == $past(addrQ[1:0]) + 2'h1;
  endproperty
  a_pageWrap: assert property (p_pageWrap) else $error("write address left group");

  property p_readInc;
    stQ == ST_RACK && sclRise && cntQ == 4'h0 && porOk && !startSeen && !stopSeen
      |=> addrQ == $past(addrQ) + 8'h01;
  endproperty
  a_readInc: assert property (p_readInc) else $error("read counter not advanced");

  property p_progIgnoresStart;
    stQ == ST_PROG && progCntQ > 16'h0001 && porOk && startSeen |=> stQ == ST_PROG;
  endproperty
  a_progIgnoresStart: assert property (p_progIgnoresStart) else $error("start during program");

  property p_openDrain;
    !sdaOe_n |-> !sdaOut && stQ != ST_IDLE && stQ != ST_PROG;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("data line driven high");
endmodule

// *** dv/i2c_master_model.sv ***
// two-wire bus master model for the eeprom bench
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // set both lines, hold n cycles
  task automatic step(input logic c, input logic l, input int n);
    scl <= c;
    sdaLow <= l;
    repeat (n) @(posedge clk);
  endtask
  task automatic txb(input logic b);
    step(1'b0, sdaLow, 4);
    step(1'b0, ~b, 4);
    step(1'b1, ~b, 8);
  endtask
  task automatic rxb(output logic b);
    step(1'b0, sdaLow, 4);
    step(1'b0, 1'b0, 4);
    step(1'b1, 1'b0, 7);
    #1 b = sdaLine;
    @(posedge clk);
  endtask
  task automatic start();
    step(1'b0, sdaLow, 4);
    step(1'b0, 1'b0, 4);
    step(1'b1, 1'b0, 8);
    step(1'b1, 1'b1, 8);
  endtask
  task automatic stop();
    step(1'b0, sdaLow, 4);
    step(1'b0, 1'b1, 4);
    step(1'b1, 1'b1, 8);
    step(1'b1, 1'b0, 8);
  endtask
  // msb first, ninth clock gives the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) txb(d[i]);
    rxb(ack);
  endtask
  // acks each byte but the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rxb(d[i]);
    txb(last);
  endtask
endmodule

// *** dv/serial_eeprom_i2c_slave_tb.sv ***
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`include "eeprom_params.svh"
module serial_eeprom_i2c_slave_tb;
  import eeprom_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sdaLow;
  logic sdaOut;
  logic sdaOe_n;
  logic sdaLine;
  logic modePin = 1'b1;
  logic writeProtect = 1'b0;
  logic supplyOk = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic a;
  logic [31:0] r;
  byte_type v;
  always #2 clk = ~clk;
  // open-drain line with pull-up
  assign sdaLine = !(sdaLow || (!sdaOe_n && !sdaOut));
  i2c_master_model u_i2c_master_model (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
  eeprom_i2c_slave u_eeprom_i2c_slave (
    .clk(clk), .rst_n(rst_n), .sclPin(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .selectStrapInputs(STRAP), .modePin(modePin),
    .writeProtectInput(writeProtect), .supplyOk(supplyOk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // single transfer; read data taken at the data-phase edge
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic sel(input logic rd, input logic [2:0] s);
    u_i2c_master_model.start();
    u_i2c_master_model.wbyte({`TYPE_CODE, s, rd}, a);
  endtask
  // address byte, data, stop starts programming
  task automatic wr(input byte_type ad, input byte_type d[$], input logic prog);
    sel(1'b0, STRAP);
    chk("wsel ack", a, 1'b0);
    u_i2c_master_model.wbyte(ad, a);
    chk("addr ack", a, 1'b0);
    foreach (d[i]) begin
      u_i2c_master_model.wbyte(d[i], a);
      chk("data ack", a, 1'b0);
    end
    u_i2c_master_model.stop();
    ahb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("prog flag", r[`STAT_PROG_BIT], prog);
    repeat (`PROG_CYCLES + 20) @(posedge clk);
  endtask
  // random read, sequential while acked
  task automatic rd(input byte_type ad, input byte_type e[$]);
    sel(1'b0, STRAP);
    u_i2c_master_model.wbyte(ad, a);
    chk("raddr ack", a, 1'b0);
    sel(1'b1, STRAP);
    chk("rsel ack", a, 1'b0);
    foreach (e[i]) begin
      u_i2c_master_model.rbyte(i == e.size() - 1, v);
      chk("read byte", v, e[i]);
    end
    u_i2c_master_model.stop();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("sda idle", sdaOe_n, 1'b1);
    chk("sda out", sdaOut, 1'b0);
    chk("hresp", hresp, 1'b0);
    chk("hreadyout", hreadyout, 1'b1);
    ahb(1'b0, `REG_CTRL, 32'h0000_0000);
    chk("ctrl reset", r, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk("unmapped", r, 32'h0000_0000);
    modePin <= 1'b0;
    wr(8'h10, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7}, 1'b1);
    rd(8'h10, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
    rd(8'h10, '{8'hA0});
    sel(1'b1, STRAP);
    u_i2c_master_model.rbyte(1'b1, v);
    chk("current read", v, 8'hA1);
    u_i2c_master_model.stop();
    modePin <= 1'b1;
    wr(8'h22, '{8'h51, 8'h52, 8'h53}, 1'b1);
    rd(8'h20, '{8'h53});
    rd(8'h22, '{8'h51, 8'h52});
    for (int s = 0; s < 8; s++) begin
      sel(1'b0, s[2:0]);
      chk("strap ack", a, s[2:0] != STRAP);
      u_i2c_master_model.stop();
    end
    u_i2c_master_model.start();
    u_i2c_master_model.wbyte({(`TYPE_CODE ^ 4'h1), STRAP, 1'b0}, a);
    chk("type ack", a, 1'b1);
    u_i2c_master_model.stop();
    ahb(1'b1, `REG_CTRL, 32'h0000_0001);
    writeProtect <= 1'b1;
    wr(8'h10, '{8'h00}, 1'b0);
    ahb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("prot flag", r[`STAT_PROT_BIT], 1'b1);
    rd(8'h10, '{8'hA0});
    writeProtect <= 1'b0;
    wr(8'h10, '{8'h77}, 1'b1);
    rd(8'h10, '{8'h77});
    // eight-byte group with variant set, then a start while programming
    sel(1'b0, STRAP);
    u_i2c_master_model.wbyte(8'h33, a);
    u_i2c_master_model.wbyte(8'h5A, a);
    u_i2c_master_model.wbyte(8'h5B, a);
    u_i2c_master_model.stop();
    sel(1'b0, STRAP);
    chk("busy ack", a, 1'b1);
    u_i2c_master_model.stop();
    rd(8'h33, '{8'h5A, 8'h5B});
    supplyOk <= 1'b0;
    repeat (4) @(posedge clk);
    sel(1'b0, STRAP);
    chk("no power ack", a, 1'b1);
    u_i2c_master_model.stop();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
